// >>> pkg/epc_defines.svh
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH
`define EPC_IDX_ARR_LO    12'h800
`define EPC_IDX_ARR_HI    12'h9ff
`define EPC_IDX_CTRL      12'h7f0
`define EPC_IDX_ACR       12'h7f1
`define EPC_IDX_NVCFG     12'h7f2
`define EPC_IDX_DIVH      12'h7f3
`define EPC_IDX_DIVL      12'h7f4
`define EPC_IDX_NVDIVH    12'h7f5
`define EPC_IDX_NVDIVL    12'h7f6
`define EPC_IDX_SYSCFG    12'h7f7
`define EPC_TGT_NVCFG     10'h200
`define EPC_TGT_NVDIVH    10'h201
`define EPC_TGT_NVDIVL    10'h202
`define EPC_SEC_OFS_HI    5'h0f
`define EPC_CTRL_HV       0
`define EPC_CTRL_AUTO     1
`define EPC_CTRL_LAT      2
`define EPC_CTRL_MLO      3
`define EPC_CTRL_MHI      4
`define EPC_CTRL_BUSY     5
`define EPC_CFG_SEC       4
`define EPC_DIVH_LOCK     7
`define EPC_SYSCFG_CLKSEL 0
`define EPC_ERASED        8'hff
`define EPC_RST_CTRL      8'h00
`define EPC_RST_SYSCFG    8'h00
`define EPC_TICKS_PGM     16'h00c8
`define EPC_TICKS_BYTE    16'h00c8
`define EPC_TICKS_BLOCK   16'h00c8
`define EPC_TICKS_BULK    16'h00c8
`endif

// >>> pkg/epc_pkg.sv
package epc_pkg;
  typedef enum logic [2:0] {
    EPC_ST_IDLE  = 3'b001,
    EPC_ST_PUMP  = 3'b010,
    EPC_ST_APPLY = 3'b100
  } epc_state_t;
  typedef enum logic [1:0] {
    EPC_MODE_PGM   = 2'b00,
    EPC_MODE_BYTE  = 2'b01,
    EPC_MODE_BLOCK = 2'b10,
    EPC_MODE_BULK  = 2'b11
  } epc_mode_t;
  typedef struct packed {
    logic       valid;
    logic [9:0] target;
    logic [7:0] data;
  } epc_latch_t;
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] idx;
  } epc_aphase_t;
endpackage

// >>> rtl/epc_ctrl.sv
// Register access over AHB-Lite and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`include "epc_defines.svh"
module epc_ctrl (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic        osc_ref_en,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             charge_pump_on
);
  import epc_pkg::*;

  function automatic logic [10:0] tgt_map(input logic [11:0] idx);
    logic [10:0] r;
    r = 11'h000;
    if (idx >= `EPC_IDX_ARR_LO && idx <= `EPC_IDX_ARR_HI)
      r = {2'b10, idx[8:0]};
    else if (idx == `EPC_IDX_NVCFG)
      r = {1'b1, `EPC_TGT_NVCFG};
    else if (idx == `EPC_IDX_NVDIVH)
      r = {1'b1, `EPC_TGT_NVDIVH};
    else if (idx == `EPC_IDX_NVDIVL)
      r = {1'b1, `EPC_TGT_NVDIVL};
    return r;
  endfunction

  function automatic logic op_allowed(input logic [9:0] tgt, input epc_mode_t md,
                                      input logic [7:0] cfg, input logic [7:0] divh);
    logic sec;
    logic insec;
    logic guard;
    logic bytewise;
    logic ok;
    sec      = ~cfg[`EPC_CFG_SEC];
    insec    = (tgt[8:4] == `EPC_SEC_OFS_HI);
    guard    = cfg[tgt[8:7]];
    bytewise = (md == EPC_MODE_PGM) || (md == EPC_MODE_BYTE);
    ok       = 1'b0;
    if (!tgt[9])
    begin
      case (md)
        EPC_MODE_PGM, EPC_MODE_BYTE: ok = ~guard & ~(sec & insec);
        EPC_MODE_BLOCK:              ok = ~sec & ~guard;
        EPC_MODE_BULK:               ok = ~sec & (cfg[3:0] == 4'h0);
        default:                     ok = 1'b0;
      endcase
    end
    else if (tgt == `EPC_TGT_NVCFG)
      ok = bytewise & ~sec;
    else
      ok = bytewise & divh[`EPC_DIVH_LOCK];
    return ok;
  endfunction

  // nonvolatile storage: set erased at power-up only, so a reset
  // leaves the array and the nonvolatile bytes as they were
  logic [7:0]  mem [0:511]     = '{default: `EPC_ERASED};
  logic [7:0]  nv_config_byte  = `EPC_ERASED;
  logic [7:0]  nv_divisor_high = `EPC_ERASED;
  logic [7:0]  nv_divisor_low  = `EPC_ERASED;

  epc_aphase_t aph_ff;
  epc_latch_t  latch_ff;
  epc_latch_t  nxt_latch;
  epc_state_t  state_ff;
  epc_state_t  nxt_state;
  epc_mode_t   op_mode_ff;
  logic [9:0]  op_tgt_ff;
  logic [7:0]  op_data_ff;
  logic        high_voltage_enable_ff;
  logic        nxt_high_voltage_enable;
  logic        bus_latch_enable_ff;
  logic        nxt_bus_latch_enable;
  logic        auto_ff;
  logic [1:0]  mode_ff;
  logic [1:0]  ctrl_spare_ff;
  logic [7:0]  array_config_shadow_ff;
  logic [7:0]  divisor_high_ff;
  logic [7:0]  divisor_low_ff;
  logic [7:0]  syscfg_ff;
  logic        boot_ff;
  logic [15:0] tb_cnt_ff;
  logic [15:0] op_ticks_ff;
  logic [31:0] hrdata_ff;

  // address phase decode
  wire         a_take     = hsel & htrans[1] & hready;
  wire         a_aligned  = (haddr[31:14] == 18'h00000) & (haddr[1:0] == 2'b00);
  wire  [11:0] a_idx      = haddr[13:2];
  wire  [10:0] a_tgt      = tgt_map(a_idx);
  wire         a_read     = a_take & ~hwrite & a_aligned;
  wire         a_rd_nvcfg = a_read & (a_idx == `EPC_IDX_NVCFG);

  // data phase decode
  wire         wr_en      = aph_ff.valid & aph_ff.write;
  wire  [7:0]  wd         = hwdata[7:0];
  wire  [10:0] d_tgt      = tgt_map(aph_ff.idx);
  wire         wr_ctrl    = wr_en & (aph_ff.idx == `EPC_IDX_CTRL);
  wire         wr_acr     = wr_en & (aph_ff.idx == `EPC_IDX_ACR);
  wire         div_locked = ~divisor_high_ff[`EPC_DIVH_LOCK];
  wire         wr_divh    = wr_en & (aph_ff.idx == `EPC_IDX_DIVH) & ~div_locked;
  wire         wr_divl    = wr_en & (aph_ff.idx == `EPC_IDX_DIVL) & ~div_locked;
  wire         wr_syscfg  = wr_en & (aph_ff.idx == `EPC_IDX_SYSCFG);
  wire         wr_tgt     = wr_en & d_tgt[10];

  // enable request, only honored with latch set and a valid target latched
  // a refused target leaves the bit set but never starts the pump
  wire         hv_set_req = wr_ctrl & wd[`EPC_CTRL_HV] & ~high_voltage_enable_ff;
  wire         hv_set_ok  = hv_set_req & bus_latch_enable_ff & latch_ff.valid;
  // an enabling write is checked against the mode bits it carries
  epc_mode_t   cur_mode;
  assign cur_mode = epc_mode_t'(wr_ctrl ? wd[`EPC_CTRL_MHI:`EPC_CTRL_MLO] : mode_ff);
  wire         set_allowed = op_allowed(latch_ff.target, cur_mode,
                                        array_config_shadow_ff, divisor_high_ff);

  // timebase
  wire         clk_sel    = syscfg_ff[`EPC_SYSCFG_CLKSEL];
  wire         ref_en     = clk_sel ? 1'b1 : osc_ref_en;
  wire  [15:0] divisor    = {1'b0, divisor_high_ff[6:0], divisor_low_ff};
  wire  [15:0] div_m1     = (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001;
  wire         in_pump    = (state_ff == EPC_ST_PUMP);
  wire         tb_tick    = in_pump & ref_en & (tb_cnt_ff >= div_m1);
  wire  [15:0] op_limit   = (op_mode_ff == EPC_MODE_PGM)   ? `EPC_TICKS_PGM :
                            (op_mode_ff == EPC_MODE_BYTE)  ? `EPC_TICKS_BYTE :
                            (op_mode_ff == EPC_MODE_BLOCK) ? `EPC_TICKS_BLOCK :
                                                             `EPC_TICKS_BULK;
  wire         auto_done  = in_pump & auto_ff & (op_ticks_ff >= op_limit);
  wire         applying   = (state_ff == EPC_ST_APPLY);

  // read selection
  wire  [7:0]  ctrl_rd    = {ctrl_spare_ff, in_pump, mode_ff, bus_latch_enable_ff,
                             auto_ff, high_voltage_enable_ff};
  wire  [7:0]  arr_raw    = mem[a_idx[8:0]];
  wire  [7:0]  nv_raw     = (a_idx == `EPC_IDX_NVCFG)  ? nv_config_byte :
                            (a_idx == `EPC_IDX_NVDIVH) ? nv_divisor_high : nv_divisor_low;
  wire  [7:0]  tgt_raw    = a_tgt[9] ? nv_raw : arr_raw;
  wire  [7:0]  tgt_rd     = (bus_latch_enable_ff & latch_ff.valid) ? latch_ff.data : tgt_raw;
  wire  [7:0]  reg_rd     = (a_idx == `EPC_IDX_CTRL)   ? ctrl_rd :
                            (a_idx == `EPC_IDX_ACR)    ? array_config_shadow_ff :
                            (a_idx == `EPC_IDX_DIVH)   ? divisor_high_ff :
                            (a_idx == `EPC_IDX_DIVL)   ? divisor_low_ff :
                            (a_idx == `EPC_IDX_SYSCFG) ? syscfg_ff : 8'h00;
  wire  [7:0]  rd_val     = a_tgt[10] ? tgt_rd : reg_rd;
  // unmapped and unused words read as zero
  wire  [7:0]  rd_sel     = a_aligned ? rd_val : 8'h00;

  assign hrdata         = hrdata_ff;
  assign hreadyout      = 1'b1;
  assign hresp          = 1'b0;
  assign charge_pump_on = in_pump;

  // control register next values
  always_comb
  begin
    nxt_high_voltage_enable = high_voltage_enable_ff;
    nxt_bus_latch_enable    = bus_latch_enable_ff;
    if (wr_ctrl)
    begin
      nxt_high_voltage_enable = wd[`EPC_CTRL_HV] & (high_voltage_enable_ff | hv_set_ok);
      nxt_bus_latch_enable    = wd[`EPC_CTRL_LAT] | high_voltage_enable_ff;
    end
    if (auto_done)
      nxt_high_voltage_enable = 1'b0;
  end

  // address/data latch
  always_comb
  begin
    nxt_latch = latch_ff;
    if (!bus_latch_enable_ff)
      nxt_latch = '0;
    else if (!high_voltage_enable_ff)
    begin
      if (wr_tgt)
        nxt_latch = '{valid: 1'b1, target: d_tgt[9:0], data: wd};
      else if (a_read & a_tgt[10])
        nxt_latch = '{valid: 1'b1, target: a_tgt[9:0], data: latch_ff.data};
    end
  end

  // pump sequencer
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      EPC_ST_IDLE:
        if (hv_set_ok & set_allowed)
          nxt_state = EPC_ST_PUMP;
      EPC_ST_PUMP:
        if (!high_voltage_enable_ff)
          nxt_state = EPC_ST_APPLY;
      EPC_ST_APPLY:
        nxt_state = EPC_ST_IDLE;
      default:
        nxt_state = EPC_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aph_ff    <= '0;
      hrdata_ff <= 32'h00000000;
    end
    else
    begin
      aph_ff <= '{valid: a_take & a_aligned, write: hwrite, idx: a_idx};
      if (a_take & ~hwrite)
        hrdata_ff <= {24'h000000, rd_sel};
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      high_voltage_enable_ff <= 1'b0;
      bus_latch_enable_ff    <= 1'b0;
      auto_ff                <= 1'b0;
      mode_ff                <= 2'b00;
      ctrl_spare_ff          <= 2'b00;
      latch_ff               <= '0;
      syscfg_ff              <= `EPC_RST_SYSCFG;
    end
    else
    begin
      high_voltage_enable_ff <= nxt_high_voltage_enable;
      bus_latch_enable_ff    <= nxt_bus_latch_enable;
      latch_ff               <= nxt_latch;
      if (wr_ctrl)
      begin
        auto_ff       <= wd[`EPC_CTRL_AUTO];
        mode_ff       <= wd[`EPC_CTRL_MHI:`EPC_CTRL_MLO];
        ctrl_spare_ff <= wd[7:6];
      end
      if (wr_syscfg)
        syscfg_ff <= wd;
    end
  end

  // volatile copies of the nonvolatile bytes
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      boot_ff                <= 1'b1;
      array_config_shadow_ff <= `EPC_ERASED;
      divisor_high_ff        <= `EPC_ERASED;
      divisor_low_ff         <= `EPC_ERASED;
    end
    else if (boot_ff)
    begin
      boot_ff                <= 1'b0;
      array_config_shadow_ff <= nv_config_byte;
      divisor_high_ff        <= nv_divisor_high;
      divisor_low_ff         <= nv_divisor_low;
    end
    else
    begin
      if (a_rd_nvcfg)
        array_config_shadow_ff[4:0] <= nv_config_byte[4:0];
      if (wr_acr)
        array_config_shadow_ff[7:5] <= wd[7:5];
      if (wr_divh)
        divisor_high_ff <= wd;
      if (wr_divl)
        divisor_low_ff <= wd;
    end
  end

  // sequencer and timebase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff    <= EPC_ST_IDLE;
      op_mode_ff  <= EPC_MODE_PGM;
      op_tgt_ff   <= 10'h000;
      op_data_ff  <= 8'h00;
      tb_cnt_ff   <= 16'h0000;
      op_ticks_ff <= 16'h0000;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == EPC_ST_IDLE)
      begin
        op_mode_ff  <= cur_mode;
        op_tgt_ff   <= latch_ff.target;
        op_data_ff  <= latch_ff.data;
        tb_cnt_ff   <= 16'h0000;
        op_ticks_ff <= 16'h0000;
      end
      else if (in_pump & ref_en)
      begin
        tb_cnt_ff <= tb_tick ? 16'h0000 : tb_cnt_ff + 16'h0001;
        if (tb_tick)
          op_ticks_ff <= op_ticks_ff + 16'h0001;
      end
    end
  end

  // per-byte hit of the operation in progress
  logic [511:0] hit;
  wire          op_bytewise = (op_mode_ff == EPC_MODE_PGM) || (op_mode_ff == EPC_MODE_BYTE);
  wire          op_arr      = ~op_tgt_ff[9];
  genvar gi;
  generate
    for (gi = 0; gi < 512; gi = gi + 1)
    begin : g_hit
      localparam logic [8:0] OFS = 9'(gi);
      assign hit[gi] = op_arr & ((op_mode_ff == EPC_MODE_BULK) ||
                                 ((op_mode_ff == EPC_MODE_BLOCK) && (OFS[8:7] == op_tgt_ff[8:7])) ||
                                 (op_bytewise && (OFS == op_tgt_ff[8:0])));
    end
  endgenerate

  wire          op_pgm  = (op_mode_ff == EPC_MODE_PGM);

  always_ff @(posedge clk)
  begin
    if (applying)
    begin
      for (int i = 0; i < 512; i++)
        if (hit[i])
          mem[i] <= op_pgm ? (mem[i] & op_data_ff) : `EPC_ERASED;
      if (op_tgt_ff == `EPC_TGT_NVCFG)
        nv_config_byte <= op_pgm ? (nv_config_byte & op_data_ff) : `EPC_ERASED;
      if (op_tgt_ff == `EPC_TGT_NVDIVH)
        nv_divisor_high <= op_pgm ? (nv_divisor_high & op_data_ff) : `EPC_ERASED;
      if (op_tgt_ff == `EPC_TGT_NVDIVL)
        nv_divisor_low <= op_pgm ? (nv_divisor_low & op_data_ff) : `EPC_ERASED;
    end
  end

endmodule

// >>> bench/epc_chk.sv
`timescale 1ns/10ps
`include "epc_defines.svh"
module epc_chk (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        charge_pump_on
);
  logic       rd_unm_ff;
  logic       rd_ctl_ff;
  logic       wr_ctl_ff;
  logic [2:0] since_en_ff;
  wire        take    = hsel && htrans[1] && hready;
  wire        rd_take = take && !hwrite;
  wire        ctl_hit = haddr == {18'h0, `EPC_IDX_CTRL, 2'b00};
  wire        en_dp   = wr_ctl_ff && hwdata[`EPC_CTRL_HV];
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      rd_unm_ff   <= 1'b0;
      rd_ctl_ff   <= 1'b0;
      wr_ctl_ff   <= 1'b0;
      since_en_ff <= 3'h7;
    end
    else
    begin
      rd_unm_ff   <= rd_take && haddr[31:14] != 18'h0;
      rd_ctl_ff   <= rd_take && ctl_hit;
      wr_ctl_ff   <= take && hwrite && ctl_hit;
      since_en_ff <= en_dp ? 3'h0 : (since_en_ff == 3'h7 ? 3'h7 : since_en_ff + 3'h1);
    end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // pump still on when control is read
  sequence pump_rd_s;
    charge_pump_on ##1 rd_ctl_ff;
  endsequence
  sequence no_rd_s;
    !rd_take;
  endsequence
  ready_const_a: assert property (hreadyout)
    else $error("hreadyout low");
  resp_okay_a: assert property (!hresp)
    else $error("hresp not okay");
  unmapped_zero_a: assert property (rd_unm_ff |-> hrdata == 32'h0)
    else $error("unmapped read not zero");
  rdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("hrdata upper bits set");
  rdata_hold_a: assert property (no_rd_s |=> $stable(hrdata))
    else $error("hrdata changed without read");
  pump_cause_a: assert property ($rose(charge_pump_on) |-> since_en_ff <= 3'h3)
    else $error("pump started without enable write");
  busy_mirror_a: assert property (rd_ctl_ff |-> hrdata[`EPC_CTRL_BUSY] == $past(charge_pump_on))
    else $error("busy bit differs from pump");
  busy_latch_a: assert property (pump_rd_s |-> hrdata[`EPC_CTRL_LAT])
    else $error("latch clear while pumping");
endmodule

// >>> bench/epc_cpu_model.sv
`timescale 1ns/10ps
module epc_cpu_model (
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  output logic             hang
);
  initial
  begin
    hsel   = 1'b1;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    hang   = 1'b0;
  end
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1 && n < 64)
    begin
      n++;
      @(posedge clk);
    end
    if (n == 64)
      hang <= 1'b1;
  endtask
  // single word transfer; released address and data lines show inverted values
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d, output logic [7:0] q);
    haddr  <= a;
    htrans <= 2'b10;
    hwrite <= w;
    wait_ready();
    htrans <= 2'b00;
    haddr  <= ~a;
    hwdata <= {24'h0, d};
    wait_ready();
    q = hrdata[7:0];
    hwdata <= ~{24'h0, d};
  endtask
endmodule

// >>> bench/epc_ctrl_bench.sv
`timescale 1ns/10ps
`include "epc_defines.svh"
module epc_ctrl_bench;
  import epc_pkg::*;
  localparam logic [11:0] ctl = `EPC_IDX_CTRL;
  logic        clk, rst_n, osc_ref_en, hsel, hwrite, hready, hresp, charge_pump_on, hang, pumped;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  int          fails, samples_checked, pump_cyc;
  epc_ctrl i_epc_ctrl (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .osc_ref_en(osc_ref_en), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .charge_pump_on(charge_pump_on));
  epc_cpu_model i_epc_cpu_model (.clk(clk), .hready(hready), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hang(hang));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    osc_ref_en <= ~osc_ref_en;
    if (charge_pump_on === 1'b1)
    begin
      pumped   <= 1'b1;
      pump_cyc <= pump_cyc + 1;
    end
  end
  task automatic conclude();
    if (fails == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    logic [7:0] q;
    i_epc_cpu_model.xfer(1'b1, {18'h0, i, 2'b00}, d, q);
  endtask
  task automatic rd(input string nm, input logic [11:0] i, input logic [7:0] e);
    logic [7:0] q;
    i_epc_cpu_model.xfer(1'b0, {18'h0, i, 2'b00}, 8'h00, q);
    chk(nm, e, q);
  endtask
  task automatic op(input logic [1:0] m, input logic [11:0] i, input logic [7:0] d, input logic au, input logic ok);
    logic [7:0] q;
    int         n;
    pumped   = 1'b0;
    pump_cyc = 0;
    wr(ctl, {3'h0, m, 1'b1, au, 1'b0});
    wr(i, d);
    wr(ctl, {3'h0, m, 1'b1, au, 1'b1});
    q = {7'h0, au};
    for (n = 0; n < 900 && q[0] === 1'b1; n++)
      i_epc_cpu_model.xfer(1'b0, {18'h0, ctl, 2'b00}, 8'h00, q);
    chk("auto clear", 8'h00, q & 8'h01);
    if (!au)
    begin
      repeat (20) @(posedge clk);
      wr(ctl, {3'h0, m, 3'h0});
    end
    repeat (3) @(posedge clk);
    rd("ctl", ctl, {3'h0, m, 1'b1, au, 1'b0});
    chk("pump", {7'h0, ok}, {7'h0, pumped});
    wr(ctl, 8'h00);
  endtask
  task automatic t_reset();
    logic [7:0] q;
    rd("ctl", ctl, 8'h00);
    rd("acr", `EPC_IDX_ACR, 8'hff);
    rd("divh", `EPC_IDX_DIVH, 8'hff);
    rd("array", `EPC_IDX_ARR_HI, `EPC_ERASED);
    i_epc_cpu_model.xfer(1'b0, 32'h0001_2000, 8'h00, q);
    chk("unmapped", 8'h00, q);
  endtask
  task automatic t_guard();
    op(EPC_MODE_PGM, 12'h880, 8'h00, 1'b0, 1'b0);
    rd("guarded", 12'h880, 8'hff);
    op(EPC_MODE_PGM, `EPC_IDX_NVCFG, 8'hf0, 1'b0, 1'b1);
    rd("acr stale", `EPC_IDX_ACR, 8'hff);
    rd("nvcfg", `EPC_IDX_NVCFG, 8'hf0);
    rd("acr", `EPC_IDX_ACR, 8'hf0);
  endtask
  task automatic t_time();
    wr(`EPC_IDX_DIVH, 8'h80);
    wr(`EPC_IDX_DIVL, 8'h02);
    op(EPC_MODE_PGM, 12'h800, 8'hfe, 1'b1, 1'b1);
    chk("osc span", 8'h1, {7'h0, pump_cyc > 795 && pump_cyc < 810});
    wr(`EPC_IDX_SYSCFG, 8'h01);
    wr(`EPC_IDX_DIVL, 8'h01);
    op(EPC_MODE_PGM, 12'h800, 8'hfd, 1'b1, 1'b1);
    chk("bus span", 8'h1, {7'h0, pump_cyc > 197 && pump_cyc < 207});
    op(EPC_MODE_PGM, 12'h800, 8'hff, 1'b0, 1'b1);
    rd("bits", 12'h800, 8'hfc);
  endtask
  task automatic t_erase();
    op(EPC_MODE_BYTE, 12'h800, 8'h00, 1'b1, 1'b1);
    rd("byte erase", 12'h800, 8'hff);
    op(EPC_MODE_PGM, 12'h97f, 8'h00, 1'b0, 1'b1);
    op(EPC_MODE_PGM, 12'h980, 8'h00, 1'b0, 1'b1);
    op(EPC_MODE_BLOCK, 12'h900, 8'h55, 1'b0, 1'b1);
    rd("block in", 12'h97f, 8'hff);
    rd("block out", 12'h980, 8'h00);
    op(EPC_MODE_BULK, 12'h9ff, 8'h55, 1'b1, 1'b1);
    rd("bulk", 12'h980, 8'hff);
  endtask
  task automatic t_latch();
    wr(ctl, 8'h01);
    rd("no latch", ctl, 8'h00);
    wr(ctl, 8'h04);
    wr(12'h810, 8'h5a);
    rd("latched", 12'h820, 8'h5a);
    wr(ctl, 8'h05);
    repeat (20) @(posedge clk);
    wr(ctl, 8'h00);
    repeat (3) @(posedge clk);
    wr(ctl, 8'h00);
    rd("relatched", 12'h820, 8'h5a);
    rd("old target", 12'h810, 8'hff);
  endtask
  task automatic t_secure();
    op(EPC_MODE_PGM, 12'h900, 8'h00, 1'b0, 1'b1);
    op(EPC_MODE_PGM, `EPC_IDX_NVCFG, 8'hef, 1'b0, 1'b1);
    rd("nvcfg", `EPC_IDX_NVCFG, 8'he0);
    rd("acr", `EPC_IDX_ACR, 8'he0);
    op(EPC_MODE_PGM, 12'h8f0, 8'h00, 1'b0, 1'b0);
    rd("secured", 12'h8f0, 8'hff);
    op(EPC_MODE_BLOCK, 12'h900, 8'h00, 1'b0, 1'b0);
    rd("block kept", 12'h900, 8'h00);
    op(EPC_MODE_PGM, `EPC_IDX_NVCFG, 8'h7f, 1'b0, 1'b0);
    rd("nvcfg", `EPC_IDX_NVCFG, 8'he0);
    op(EPC_MODE_BYTE, 12'h900, 8'h00, 1'b0, 1'b1);
    rd("byte", 12'h900, 8'hff);
  endtask
  task automatic t_lock();
    op(EPC_MODE_PGM, `EPC_IDX_NVDIVH, 8'h00, 1'b0, 1'b1);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rd("divh", `EPC_IDX_DIVH, 8'h00);
    rd("acr", `EPC_IDX_ACR, 8'he0);
    wr(`EPC_IDX_DIVL, 8'h01);
    rd("divl", `EPC_IDX_DIVL, 8'hff);
    wr(ctl, 8'h04);
    wr(ctl, 8'h05);
    rd("no target", ctl, 8'h04);
    wr(ctl, 8'h00);
    op(EPC_MODE_PGM, `EPC_IDX_NVDIVL, 8'h00, 1'b0, 1'b0);
    rd("nvdivl", `EPC_IDX_NVDIVL, 8'hff);
  endtask
  initial
  begin
    rst_n           = 1'b0;
    osc_ref_en      = 1'b0;
    pumped          = 1'b0;
    pump_cyc        = 0;
    fails           = 0;
    samples_checked = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_guard();
    t_time();
    t_erase();
    t_latch();
    t_secure();
    t_lock();
    conclude();
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    conclude();
  end
  always @(posedge hang)
  begin
    fails++;
    conclude();
  end
endmodule
bind epc_ctrl epc_chk i_epc_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .charge_pump_on(charge_pump_on));
